// ===== logic/rtccal_defines.svh
`ifndef RTCCAL_DEFINES_SVH
`define RTCCAL_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define RTCCAL_IDX_WDAY 10'h003
`define RTCCAL_IDX_MDAY 10'h004
`define RTCCAL_IDX_MONTH 10'h005
`define RTCCAL_IDX_YEAR 10'h006
`define RTCCAL_IDX_TRIM 10'h007

// Field positions inside the byte registers.
`define RTCCAL_CENTURY_BIT 7
`define RTCCAL_TRIM_SIGN_BIT 6

// Values taken at reset; the calendar starts on day 01, month 01, year 00.
`define RTCCAL_RST_WDAY 3'h0
`define RTCCAL_RST_MDAY 6'h01
`define RTCCAL_RST_MONTH 5'h01
`define RTCCAL_RST_YEAR 8'h00
`define RTCCAL_RST_TRIM 7'h00

// Counting limits in BCD.
`define RTCCAL_WDAY_LAST 3'h6
`define RTCCAL_MONTH_LAST 5'h12
`define RTCCAL_YEAR_LAST 8'h99
`define RTCCAL_MDAY_FIRST 6'h01
`define RTCCAL_MONTH_FIRST 5'h01

// One second is 32768 oscillator cycles; the divider counts 0 to this value.
`define RTCCAL_NOM_LAST 16'h7fff

// Seconds values, in BCD, at which the trim correction applies.
`define RTCCAL_TRIM_PT0 7'h00
`define RTCCAL_TRIM_PT1 7'h20
`define RTCCAL_TRIM_PT2 7'h40

`endif

// ===== logic/rtccal_pkg.sv
`default_nettype none

package rtccal_pkg;

    // Whole state of the calendar and trim block.
    typedef struct packed {
        logic [2:0] wday;
        logic [5:0] mday;
        logic [4:0] month;
        logic century;
        logic [7:0] year;
        logic [6:0] trim;
        logic trim_en;
        logic skip;
        logic [15:0] div;
        logic pu_q;
        logic sec_tick;
        logic [4:0] wr_sel;
        logic [31:0] rdata;
    } rtccal_state_t;

endpackage

`default_nettype wire

// ===== logic/rtccal_core.sv
// What this block does
// - Weekday advances by one on each day carry, with the day of month.
// - Weekday counts 000 to 110 then wraps to 000.
// - Day of month runs 1 to 31, 30, 29 or 28 by month and leap year.
// - Day of month wrapping back to 1 increments the month.
// - Month counts 1 to 12; wrap to 1 carries into the year.
// - Year counts 00 to 99; years divisible by four give February 29 days.
// - Century flag toggles each time the year wraps 99 to 00.
// - Calendar counters hold and present BCD digits.
// - Untrimmed, a seconds tick comes every 32768 oscillator cycles.
// - Trim applies only to the second at seconds 00, 20 or 40.
// - Writing the trim bits enables trim with the new value.
// - A trim write at a correction point skips that correction.
// - Sign 0 lengthens the corrected second by (magnitude minus one) times two.
// - Sign 1 shortens it by (inverted magnitude plus one) times two.
// - Magnitude bits five to one all zero keep the nominal length.
// - Trim changes only the seconds count, never the oscillator tick itself.
// - Rising power-up flag clears every trim bit.
// - Day carry arrives when the hours roll over to a new day.
`include "rtccal_defines.svh"
`default_nettype none

module rtccal_core (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave port.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Oscillator and time counter side.
    input wire logic osc_tick,
    input wire logic day_carry,
    input wire logic [6:0] sec_value,
    input wire logic power_up_flag,
    output logic sec_tick
);
    import rtccal_pkg::*;

    rtccal_state_t st;
    rtccal_state_t nx;
    logic addr_ph;
    logic [9:0] widx;
    logic [4:0] sel;
    logic leap;
    logic [5:0] mday_last;
    logic mday_wrap;
    logic month_wrap;
    logic year_wrap;
    logic at_point;
    logic corr;
    logic [15:0] shrink;
    logic [15:0] last;
    logic [7:0] wbyte;
    logic [7:0] mday_inc;
    logic [7:0] month_inc;
    logic [7:0] year_inc;

    // Two-digit BCD increment; the caller handles the wrap value.
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // The slave never waits and never errors.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st.rdata;
    assign sec_tick = st.sec_tick;
    assign wbyte = hwdata[7:0];

    // Address decode on the word index; other addresses read zero.
    assign addr_ph = hsel && hready && htrans[1];
    assign widx = haddr[11:2];
    always_comb begin
        sel = 5'h00;
        if (haddr[31:12] == 20'h00000) begin
            sel[0] = (widx == `RTCCAL_IDX_WDAY);
            sel[1] = (widx == `RTCCAL_IDX_MDAY);
            sel[2] = (widx == `RTCCAL_IDX_MONTH);
            sel[3] = (widx == `RTCCAL_IDX_YEAR);
            sel[4] = (widx == `RTCCAL_IDX_TRIM);
        end
    end

    // Leap test on BCD digits: even tens with units 0/4/8, odd tens with 2/6.
    always_comb begin
        if (st.year[4] == 1'b0) begin
            leap = (st.year[3:0] == 4'h0) || (st.year[3:0] == 4'h4) ||
                (st.year[3:0] == 4'h8);
        end else begin
            leap = (st.year[3:0] == 4'h2) || (st.year[3:0] == 4'h6);
        end
    end

    // Last day of the current month.
    always_comb begin
        case (st.month)
            5'h02: mday_last = leap ? 6'h29 : 6'h28;
            5'h04, 5'h06, 5'h09, 5'h11: mday_last = 6'h30;
            default: mday_last = 6'h31;
        endcase
    end

    // Carry chain; a day carry comes from the hour rollover outside.
    assign mday_wrap = day_carry && (st.mday == mday_last);
    assign month_wrap = mday_wrap && (st.month == `RTCCAL_MONTH_LAST);
    assign year_wrap = month_wrap && (st.year == `RTCCAL_YEAR_LAST);

    // Incremented digit pairs for the carry chain, formed once as full bytes.
    // The narrow fields keep only their low bits, which never lose a digit below the wrap value.
    assign mday_inc = bcd_inc({2'b00, st.mday});
    assign month_inc = bcd_inc({3'b000, st.month});
    assign year_inc = bcd_inc(st.year);

    // Correction point and the trimmed divider length.
    assign at_point = (sec_value == `RTCCAL_TRIM_PT0) || (sec_value == `RTCCAL_TRIM_PT1) ||
        (sec_value == `RTCCAL_TRIM_PT2);
    assign corr = st.trim_en && at_point && !st.skip && (st.trim[5:1] != 5'h00);
    always_comb begin
        shrink = ({10'h000, ~st.trim[5:0]} + 16'h0001) << 1;
        if (!corr) begin
            last = `RTCCAL_NOM_LAST;
        end else if (!st.trim[`RTCCAL_TRIM_SIGN_BIT]) begin
            last = `RTCCAL_NOM_LAST + {9'h000, st.trim[5:0] - 6'h01, 1'b0};
        end else begin
            last = `RTCCAL_NOM_LAST - shrink;
        end
    end

    // Next-state logic for the whole block.
    always_comb begin
        nx = st;
        nx.sec_tick = 1'b0;
        nx.pu_q = power_up_flag;
        // Bus address phase: latch the target, and the read data for the data phase.
        nx.wr_sel = (addr_ph && hwrite) ? sel : 5'h00;
        if (addr_ph && !hwrite) begin
            nx.rdata = 32'h00000000;
            unique case (1'b1)
                sel[0]: nx.rdata[2:0] = st.wday;
                sel[1]: nx.rdata[5:0] = st.mday;
                sel[2]: nx.rdata[7:0] = {st.century, 2'b00, st.month};
                sel[3]: nx.rdata[7:0] = st.year;
                sel[4]: nx.rdata[6:0] = st.trim;
                default: nx.rdata = 32'h00000000;
            endcase
        end

        // Calendar counting on the day carry.
        if (day_carry) begin
            nx.wday = (st.wday == `RTCCAL_WDAY_LAST) ? 3'h0 : st.wday + 3'h1;
            nx.mday = mday_wrap ? `RTCCAL_MDAY_FIRST : mday_inc[5:0];
        end
        if (mday_wrap) begin
            nx.month = month_wrap ? `RTCCAL_MONTH_FIRST : month_inc[4:0];
        end
        if (month_wrap) begin
            nx.year = year_wrap ? 8'h00 : year_inc;
        end
        if (year_wrap) begin
            nx.century = ~st.century;
        end

        // A host write wins over a carry into the same register.
        if (st.wr_sel[0]) begin
            nx.wday = wbyte[2:0];
        end
        if (st.wr_sel[1]) begin
            nx.mday = wbyte[5:0];
        end
        if (st.wr_sel[2]) begin
            nx.month = wbyte[4:0];
            nx.century = wbyte[`RTCCAL_CENTURY_BIT];
        end
        if (st.wr_sel[3]) begin
            nx.year = wbyte;
        end

        // The skip mark lasts while the seconds stay on the point that was written at.
        if (!at_point) begin
            nx.skip = 1'b0;
        end
        if (st.wr_sel[4]) begin
            nx.trim = wbyte[6:0];
            nx.trim_en = 1'b1;
            if (at_point) begin
                nx.skip = 1'b1;
            end
        end
        // Power-up clears trim even against a write in the same cycle.
        if (power_up_flag && !st.pu_q) begin
            nx.trim = `RTCCAL_RST_TRIM;
            nx.trim_en = 1'b0;
        end

        // Seconds divider; trim moves only its end count, the oscillator is untouched.
        if (osc_tick) begin
            if (st.div >= last) begin
                nx.div = 16'h0000;
                nx.sec_tick = 1'b1;
            end else begin
                nx.div = st.div + 16'h0001;
            end
        end
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st.wday <= `RTCCAL_RST_WDAY;
            st.mday <= `RTCCAL_RST_MDAY;
            st.month <= `RTCCAL_RST_MONTH;
            st.century <= 1'b0;
            st.year <= `RTCCAL_RST_YEAR;
            st.trim <= `RTCCAL_RST_TRIM;
            st.trim_en <= 1'b0;
            st.skip <= 1'b0;
            st.div <= 16'h0000;
            st.pu_q <= 1'b0;
            st.sec_tick <= 1'b0;
            st.wr_sel <= 5'h00;
            st.rdata <= 32'h00000000;
        end else begin
            st <= nx;
        end
    end

    // Checks on the counting and trim logic.
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    wday_step_a: assert property (
        day_carry && !st.wr_sel[0] && st.wday < `RTCCAL_WDAY_LAST |=>
        st.wday == $past(st.wday) + 3'h1)
        else $error("weekday did not step on day carry");

    wday_wrap_a: assert property (
        day_carry && !st.wr_sel[0] && st.wday == `RTCCAL_WDAY_LAST |=> st.wday == 3'h0)
        else $error("weekday did not wrap after code 110");

    mday_wrap_a: assert property (
        day_carry && !st.wr_sel[1] && st.month == 5'h04 && st.mday == 6'h30 |=>
        st.mday == 6'h01)
        else $error("day of month did not wrap after day 30 of a 30-day month");

    month_step_a: assert property (
        mday_wrap && !st.wr_sel[2] && st.month == 5'h09 |=> st.month == 5'h10)
        else $error("month did not step in BCD after last day");

    year_carry_a: assert property (
        month_wrap && !st.wr_sel[2] && !st.wr_sel[3] && st.year == 8'h19 |=>
        st.month == 5'h01 && st.year == 8'h20)
        else $error("month wrap did not carry into year");

    leap_feb_a: assert property (
        day_carry && !st.wr_sel[1] && st.month == 5'h02 && st.mday == 6'h28 &&
        st.year == 8'h96 |=> st.mday == 6'h29)
        else $error("leap year February did not reach day 29");

    century_flip_a: assert property (
        year_wrap && !st.wr_sel[2] && !st.wr_sel[3] |=>
        st.century != $past(st.century) && st.year == 8'h00)
        else $error("century flag did not toggle on year wrap");

    bcd_digit_a: assert property (
        day_carry && !st.wr_sel[1] && st.mday[3:0] == 4'h9 && st.mday != mday_last |=>
        st.mday[3:0] == 4'h0)
        else $error("day of month units left BCD range");

    nominal_len_a: assert property (
        !at_point && osc_tick && st.div == `RTCCAL_NOM_LAST |=> sec_tick && st.div == 16'h0000)
        else $error("untrimmed second not 32768 cycles long");

    no_early_a: assert property (
        !at_point && osc_tick && st.div < `RTCCAL_NOM_LAST |=> !sec_tick)
        else $error("seconds tick came early outside a correction point");

    skip_write_a: assert property (
        st.wr_sel[4] && at_point |=> st.skip && last == `RTCCAL_NOM_LAST || !at_point)
        else $error("trim write at a correction point did not skip it");

    trim_load_a: assert property (
        st.wr_sel[4] && !(power_up_flag && !st.pu_q) |=>
        st.trim_en && st.trim == $past(wbyte[6:0]))
        else $error("trim write did not load and enable trim");

    flat_trim_a: assert property (
        st.trim[5:1] == 5'h00 |-> last == `RTCCAL_NOM_LAST)
        else $error("magnitude zero changed the second length");

    long_second_a: assert property (
        corr && !st.trim[`RTCCAL_TRIM_SIGN_BIT] && st.trim[5:0] == 6'h07 |->
        last == 16'h800b)
        else $error("positive trim of 7 not 32780 cycles");

    short_second_a: assert property (
        corr && st.trim == 7'h7e |-> last == 16'h7ffb)
        else $error("negative trim of 7e not 32764 cycles");

    power_clear_a: assert property (
        power_up_flag && !st.pu_q |=> st.trim == 7'h00 && !st.trim_en)
        else $error("power-up did not clear trim");

    feb_common_a: assert property (
        day_carry && !st.wr_sel[1] && !st.wr_sel[2] && st.month == 5'h02 &&
        st.mday == 6'h28 && st.year == 8'h01 |=> st.mday == 6'h01 && st.month == 5'h03)
        else $error("common year February did not end at day 28");

    long_month_a: assert property (
        day_carry && !st.wr_sel[1] && st.month == 5'h07 && st.mday == 6'h30 |=>
        st.mday == 6'h31)
        else $error("31-day month ended at day 30");

    mday_tens_a: assert property (
        day_carry && !st.wr_sel[1] && st.mday == 6'h09 |=> st.mday == 6'h10)
        else $error("day of month did not carry into the tens digit");

    cal_hold_a: assert property (
        !day_carry && st.wr_sel[1:0] == 2'h0 |=> $stable(st.mday) && $stable(st.wday))
        else $error("calendar moved without a day carry");

    // Read checks look one cycle on, where the registered read data stands.
    wday_read_a: assert property (
        addr_ph && !hwrite && sel[0] |=> hrdata[31:3] == 29'h0)
        else $error("weekday unused bits did not read zero");

    mday_read_a: assert property (
        addr_ph && !hwrite && sel[1] |=> hrdata[31:6] == 26'h0)
        else $error("day of month unused bits did not read zero");

    month_read_a: assert property (
        addr_ph && !hwrite && sel[2] |=> hrdata[31:8] == 24'h0 && hrdata[6:5] == 2'h0)
        else $error("month unused bits did not read zero");

    trim_read_a: assert property (
        addr_ph && !hwrite && sel[4] |=> hrdata[31:7] == 25'h0)
        else $error("trim top bit did not read zero");

    trim_keep_a: assert property (
        !st.wr_sel[4] && !(power_up_flag && !st.pu_q) |=> $stable(st.trim))
        else $error("trim changed without a write");

    skip_flat_a: assert property (
        st.skip |-> last == `RTCCAL_NOM_LAST)
        else $error("correction applied while skipped");

    osc_only_a: assert property (
        sec_tick |-> $past(osc_tick))
        else $error("seconds tick without an oscillator tick");

    // Main scenarios worth seeing.
    century_c: cover property (year_wrap);
    leap_day_c: cover property (day_carry && st.month == 5'h02 && st.mday == 6'h28 && leap);
    trimmed_tick_c: cover property (corr && osc_tick && st.div == last);
    skip_c: cover property (st.wr_sel[4] && at_point);
    short_tick_c: cover property (corr && st.trim[`RTCCAL_TRIM_SIGN_BIT] && osc_tick && st.div >= last);

endmodule

`default_nettype wire

// ===== dv/rtccal_core_tb.sv
`include "rtccal_defines.svh"
`default_nettype none

module rtccal_core_tb;
    timeunit 1ns;
    timeprecision 100ps;

    // Bench-driven inputs, all given a value at time zero.
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic osc_tick = 1'b0;
    logic day_carry = 1'b0;
    logic power_up_flag = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [6:0] sec_value = 7'h15;
    wire logic hreadyout;
    wire logic hresp;
    wire logic sec_tick;
    wire logic [31:0] hrdata;
    int fails = 0;
    int compares = 0;
    int osc_cnt = 0;
    int sec_cnt = 0;
    int sec_prev = 0;
    int sec_len = 0;
    // Each entry: year, month, day written; then day, month, year expected after one carry.
    logic [47:0] cal_tbl [13] = '{48'h04_02_28_29_02_04, 48'h04_02_29_01_03_04,
        48'h01_02_28_01_03_01, 48'h00_02_29_01_03_00, 48'h23_04_30_01_05_23,
        48'h23_07_30_31_07_23, 48'h23_01_09_10_01_23, 48'h19_09_30_01_10_19,
        48'h99_12_31_01_81_00, 48'h99_92_31_01_01_00, 48'h18_08_31_01_09_18,
        48'h96_02_28_29_02_96, 48'h19_12_31_01_01_20};

    // The single slave's ready is the bus ready.
    rtccal_core DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .osc_tick(osc_tick),
        .day_carry(day_carry), .sec_value(sec_value), .power_up_flag(power_up_flag),
        .sec_tick(sec_tick)
    );

    // Clock of 20 ns period.
    always #10 hclk = ~hclk;

    // Counts oscillator pulses as the core samples them, and the length of each second.
    // Counting here, not in the driver, keeps the count free of races at the clock edge.
    always @(posedge hclk) begin
        if (sec_tick === 1'b1) begin
            sec_len = osc_cnt - sec_prev;
            sec_prev = osc_cnt;
            sec_cnt++;
        end
        if (osc_tick === 1'b1) begin
            osc_cnt++;
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Waits for ready; only the watchdog ends a wait that never finishes.
    // The slave has no wait states, so each phase ends at the first edge.
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1);
        chk("ready wait cycles", 32'h1, n);
    endtask

    // One single word transfer: address phase held until ready, then the data phase.
    task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] wd,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, idx, 2'h0};
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_ready();
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        xfer(1'b1, idx, d, rd);
    endtask

    task automatic rdc(input logic [9:0] idx, input logic [7:0] exp, input string nm);
        logic [31:0] rd;
        xfer(1'b0, idx, 8'h00, rd);
        chk(nm, {24'h0, exp}, rd);
    endtask

    task automatic carry();
        @(posedge hclk) day_carry <= 1'b1;
        @(posedge hclk) day_carry <= 1'b0;
    endtask

    task automatic t_reset();
        rdc(`RTCCAL_IDX_TRIM, 8'h00, "trim after reset");
        rdc(`RTCCAL_IDX_MDAY, 8'h01, "day after reset");
        wr(10'h008, 8'hff);
        rdc(10'h008, 8'h00, "unmapped");
    endtask

    // Unused bits are dropped; a power-up edge clears the trim value.
    task automatic t_regs();
        wr(`RTCCAL_IDX_MDAY, 8'hc5);
        rdc(`RTCCAL_IDX_MDAY, 8'h05, "day unused bits");
        wr(`RTCCAL_IDX_MONTH, 8'hf2);
        rdc(`RTCCAL_IDX_MONTH, 8'h92, "month unused bits");
        wr(`RTCCAL_IDX_TRIM, 8'h7f);
        rdc(`RTCCAL_IDX_TRIM, 8'h7f, "trim top bit");
        @(posedge hclk) power_up_flag <= 1'b1;
        repeat (2) @(posedge hclk);
        rdc(`RTCCAL_IDX_TRIM, 8'h00, "trim after power-up");
    endtask

    task automatic t_wday();
        wr(`RTCCAL_IDX_MONTH, 8'h01);
        wr(`RTCCAL_IDX_MDAY, 8'h05);
        wr(`RTCCAL_IDX_WDAY, 8'hfd);
        rdc(`RTCCAL_IDX_WDAY, 8'h05, "weekday unused bits");
        carry();
        rdc(`RTCCAL_IDX_WDAY, 8'h06, "weekday step");
        rdc(`RTCCAL_IDX_MDAY, 8'h06, "day with weekday");
        carry();
        rdc(`RTCCAL_IDX_WDAY, 8'h00, "weekday wrap");
    endtask

    // Month ends, leap years, BCD digit carries and the century flip, one carry each.
    task automatic t_cal();
        logic [47:0] e;
        for (int i = 0; i < 13; i++) begin
            e = cal_tbl[i];
            wr(`RTCCAL_IDX_YEAR, e[47:40]);
            wr(`RTCCAL_IDX_MONTH, e[39:32]);
            wr(`RTCCAL_IDX_MDAY, e[31:24]);
            carry();
            rdc(`RTCCAL_IDX_MDAY, e[23:16], "day");
            rdc(`RTCCAL_IDX_MONTH, e[15:8], "month");
            rdc(`RTCCAL_IDX_YEAR, e[7:0], "year");
        end
    endtask

    // The oscillator pulse is held high, one tick per clock, so two seconds fit the run budget.
    // A tick or two past the seconds pulse only moves the next second's start, not its length.
    task automatic run_period(input int target);
        int n;
        n = 0;
        @(posedge hclk) osc_tick <= 1'b1;
        while (sec_cnt < target && n < 40000) begin
            @(posedge hclk);
            n++;
        end
        osc_tick <= 1'b0;
    endtask

    // Trim is written away from a correction point, so neither second is skipped.
    task automatic t_trim();
        wr(`RTCCAL_IDX_TRIM, 8'h07);
        @(posedge hclk) sec_value <= 7'h20;
        run_period(1);
        chk("lengthened second", 32'd32780, sec_len);
        @(posedge hclk) sec_value <= 7'h15;
        wr(`RTCCAL_IDX_TRIM, 8'h7e);
        @(posedge hclk) sec_value <= 7'h40;
        run_period(2);
        chk("shortened second", 32'd32764, sec_len);
    endtask

    task automatic give_verdict();
        if (fails == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence after four cycles of reset.
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_regs();
        t_wday();
        t_cal();
        t_trim();
        give_verdict();
    end

    // Two trimmed seconds take about 66000 cycles; the limit leaves margin.
    initial begin
        repeat (80000) @(posedge hclk);
        fails++;
        give_verdict();
    end
endmodule

`default_nettype wire
